// ---- core/mdu_top.sv ----
// Chosen here: the address map and the address-and-strobe port.
`default_nettype none
// Function
// - Multiply sixteen by sixteen into thirty-two bits
// - Divide 32 by 16: quotient, remainder
// - Remainder zero after multiply, remainder after divide
// - Reset clears remainder, operand A, operand B
// - Remainder cleared when start bit set
// - Operand A 32 bits, two 16-bit halves
// - Multiply start forces upper half zero
// - Multiplier low half; dividend whole; quotient replaces
// - Operand A takes intermediates from next clock
// - Operand A halves take byte or halfword writes
// - Operand B multiplicand/divisor, byte or halfword writes
// - Remainder readable by byte or halfword
// - Start bit begins, self-clears at finish
// - Multiply finishes after sixteen clocks
// - Divide finishes after thirty-two clocks
// - Completion pulse after results stored
module mdu_top
	import mdu_pkg::*;
(
	input  wire logic        clk_i,     // 125 MHz clock
	input  wire logic        reset_i,   // Async reset, active high
	input  wire logic [2:0]  addr_i,    // Register index
	input  wire logic [15:0] wdata_i,   // Write data
	input  wire logic [1:0]  be_i,      // Byte enables, low/high lane
	input  wire logic        wr_i,      // Write strobe
	input  wire logic        rd_i,      // Read strobe
	output logic      [15:0] rdata_o,   // Read data, cycle after strobe
	output logic             busy_o,    // Start bit mirror
	output logic             arith_done_irq_o // Completion pulse
);
	logic [31:0] operand_a_result_ff;  // Operand A and result
	logic [15:0] operand_b_divisor_ff; // Operand B
	logic [15:0] remainder_result_ff;  // Remainder
	logic [15:0] mcand_ff;             // Multiplier bits consumed MSB first
	logic        arith_start_bit_ff;   // Running flag
	logic        mul_div_select_ff;    // High selects multiply
	logic [5:0]  count_ff;             // Cycles left
	mdu_state_t  state_ff;             // Sequencer
	logic        done_ff;              // Completion pulse register
	logic [15:0] rdata_ff;             // Read data register
	logic [31:0] nxt_acc_a;            // Step outputs
	logic [15:0] nxt_rem;
	logic        wr_ctrl;              // Control write decode
	logic        start_req;            // Start written while idle
	logic        last_step;            // Final iteration this cycle
	logic [15:0] merged;               // Byte-merged write value

	assign wr_ctrl   = wr_i && addr_i == MDU_IDX_ARITH_CTRL;
	assign start_req = wr_ctrl && wdata_i[MDU_CTRL_START_POS]
		&& state_ff == MDU_IDLE;
	assign last_step = state_ff == MDU_BUSY && count_ff == 6'h01;
	assign busy_o           = arith_start_bit_ff;
	assign arith_done_irq_o = done_ff;
	assign rdata_o          = rdata_ff;

	// Byte-lane merge against the addressed register's old value
	function automatic logic [15:0] lane_merge(input logic [15:0] old,
		input logic [15:0] nw, input logic [1:0] be);
		logic [15:0] r;
		r = old;
		if ((be & MDU_BE_LOW) != 2'h0)
			r[7:0] = nw[7:0];
		if ((be & MDU_BE_HIGH) != 2'h0)
			r[15:8] = nw[15:8];
		return r;
	endfunction : lane_merge

	// Old value of the addressed operand A half or of operand B
	always_comb
	begin
		case (addr_i)
			MDU_IDX_OPA_LOWER:
				merged = lane_merge(operand_a_result_ff[15:0], wdata_i, be_i);
			MDU_IDX_OPA_UPPER:
				merged = lane_merge(operand_a_result_ff[31:16], wdata_i, be_i);
			MDU_IDX_OPB_DIVISOR:
				merged = lane_merge(operand_b_divisor_ff, wdata_i, be_i);
			default:
				merged = wdata_i;
		endcase
	end

	// Datapath iteration
	mdu_step u_step (
		.mul_mode_i  (mul_div_select_ff),
		.acc_a_i     (operand_a_result_ff),
		.rem_i       (remainder_result_ff),
		.opb_i       (operand_b_divisor_ff),
		.mcand_i     (mcand_ff),
		.nxt_acc_a_o (nxt_acc_a),
		.nxt_rem_o   (nxt_rem)
	);

	// Sequencer: start, count, self-clear of start bit
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_ff           <= MDU_IDLE;
			count_ff           <= 6'h00;
			arith_start_bit_ff <= 1'b0;
			mul_div_select_ff  <= MDU_RST_CTRL[MDU_CTRL_SEL_POS];
			done_ff            <= 1'b0;
		end
		else
		begin
			done_ff <= 1'b0;
			case (state_ff)
				MDU_IDLE:
				begin
					if (wr_ctrl)
						mul_div_select_ff <= wdata_i[MDU_CTRL_SEL_POS];
					if (start_req)
					begin
						// Cycle count by mode
						state_ff           <= MDU_BUSY;
						arith_start_bit_ff <= 1'b1;
						count_ff <= wdata_i[MDU_CTRL_SEL_POS] ?
							MDU_MUL_CYCLES : MDU_DIV_CYCLES;
					end
				end
				MDU_BUSY:
				begin
					if (wr_ctrl && !wdata_i[MDU_CTRL_START_POS])
					begin
						// Software abort stops without a done pulse
						state_ff           <= MDU_IDLE;
						arith_start_bit_ff <= 1'b0;
					end
					else if (last_step)
					begin
						state_ff           <= MDU_IDLE;
						arith_start_bit_ff <= 1'b0;
						done_ff            <= 1'b1;
					end
					count_ff <= count_ff - 6'h01;
				end
				default:
					state_ff <= MDU_IDLE;
			endcase
		end
	end

	// Operand A: bus writes while idle, iterations while busy
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			operand_a_result_ff <= {MDU_RST_HALF, MDU_RST_HALF};
		else if (state_ff == MDU_BUSY)
			operand_a_result_ff <= nxt_acc_a;
		else if (start_req && wdata_i[MDU_CTRL_SEL_POS])
			// Multiply: clear upper half, accumulate from zero
			operand_a_result_ff <= {MDU_RST_HALF, MDU_RST_HALF};
		else if (wr_i && addr_i == MDU_IDX_OPA_LOWER)
			operand_a_result_ff[15:0] <= merged;
		else if (wr_i && addr_i == MDU_IDX_OPA_UPPER)
			operand_a_result_ff[31:16] <= merged;
	end

	// Saved multiplier, shifted left each multiply step
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			mcand_ff <= MDU_RST_HALF;
		else if (start_req)
			mcand_ff <= operand_a_result_ff[15:0];
		else if (state_ff == MDU_BUSY)
			mcand_ff <= {mcand_ff[14:0], 1'b0};
	end

	// Operand B: writes ignored while running to keep the result sane
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			operand_b_divisor_ff <= MDU_RST_HALF;
		else if (wr_i && addr_i == MDU_IDX_OPB_DIVISOR
			&& state_ff == MDU_IDLE)
			operand_b_divisor_ff <= merged;
	end

	// Remainder: cleared at start, then partial remainders
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			remainder_result_ff <= MDU_RST_HALF;
		else if (start_req)
			remainder_result_ff <= MDU_RST_HALF;
		else if (state_ff == MDU_BUSY)
			remainder_result_ff <= nxt_rem;
	end

	// Read data, valid the cycle after the strobe
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			rdata_ff <= MDU_RST_HALF;
		else if (rd_i)
		begin
			case (addr_i)
				MDU_IDX_REM_RESULT:  rdata_ff <= remainder_result_ff;
				MDU_IDX_OPA_LOWER:   rdata_ff <= operand_a_result_ff[15:0];
				MDU_IDX_OPA_UPPER:   rdata_ff <= operand_a_result_ff[31:16];
				MDU_IDX_OPB_DIVISOR: rdata_ff <= operand_b_divisor_ff;
				MDU_IDX_ARITH_CTRL:
					rdata_ff <= {8'h00, arith_start_bit_ff, 6'h00,
						mul_div_select_ff};
				default:             rdata_ff <= 16'h0000;
			endcase
		end
	end
endmodule : mdu_top
`default_nettype wire

// ---- core/mdu_pkg.sv ----
`default_nettype none
package mdu_pkg;
	// Register indices on the plain register port (address of one word each)
	localparam logic [2:0] MDU_IDX_REM_RESULT   = 3'h0;
	localparam logic [2:0] MDU_IDX_OPA_LOWER    = 3'h1;
	localparam logic [2:0] MDU_IDX_OPA_UPPER    = 3'h2;
	localparam logic [2:0] MDU_IDX_OPB_DIVISOR  = 3'h3;
	localparam logic [2:0] MDU_IDX_ARITH_CTRL   = 3'h4;
	// Field positions in the control register
	localparam int       MDU_CTRL_START_POS     = 7;
	localparam int       MDU_CTRL_SEL_POS       = 0;
	// Values after reset
	localparam logic [15:0] MDU_RST_HALF        = 16'h0000;
	localparam logic [7:0]  MDU_RST_CTRL        = 8'h00;
	// Cycle counts of one operation
	localparam logic [5:0]  MDU_MUL_CYCLES      = 6'h10;
	localparam logic [5:0]  MDU_DIV_CYCLES      = 6'h20;
	// Byte lane strobes
	localparam logic [1:0]  MDU_BE_LOW          = 2'h1;
	localparam logic [1:0]  MDU_BE_HIGH         = 2'h2;
	// Sequencer states
	typedef enum logic [0:0] {MDU_IDLE, MDU_BUSY} mdu_state_t;
endpackage : mdu_pkg
`default_nettype wire

// ---- core/mdu_step.sv ----
`default_nettype none
// One iteration of shift-add multiply or restoring divide
module mdu_step
	import mdu_pkg::*;
(
	input  wire logic        mul_mode_i,  // High for multiply
	input  wire logic [31:0] acc_a_i,     // Operand A / quotient shifter
	input  wire logic [15:0] rem_i,       // Partial remainder
	input  wire logic [15:0] opb_i,       // Multiplicand or divisor
	input  wire logic [15:0] mcand_i,     // Saved multiplier bits
	output logic      [31:0] nxt_acc_a_o, // Next operand A
	output logic      [15:0] nxt_rem_o    // Next remainder
);
	logic [16:0] trial;  // Remainder shifted with next dividend bit
	logic [16:0] diff;   // Trial minus divisor
	logic [32:0] sum;    // Shift-add partial

	// Combinational step
	always_comb
	begin
		trial = {rem_i, acc_a_i[31]};
		diff  = trial - {1'b0, opb_i};
		sum   = 33'h0;
		if (mul_mode_i)
		begin
			// MSB-first shift-add of the saved multiplier bit
			sum = {acc_a_i, 1'b0} + (mcand_i[15] ? {17'h0, opb_i} : 33'h0);
			nxt_acc_a_o = sum[31:0];
			nxt_rem_o   = MDU_RST_HALF;
		end
		else if (!diff[16])
		begin
			// Divisor fits: subtract, quotient bit one
			nxt_acc_a_o = {acc_a_i[30:0], 1'b1};
			nxt_rem_o   = diff[15:0];
		end
		else
		begin
			// Does not fit: keep remainder, quotient bit zero
			nxt_acc_a_o = {acc_a_i[30:0], 1'b0};
			nxt_rem_o   = trial[15:0];
		end
	end
endmodule : mdu_step
`default_nettype wire

// ---- sim/mdu_top_asserts.sv ----
`default_nettype none
// Watches timing of start, busy span and done pulse
module mdu_top_asserts
	import mdu_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic [2:0]  addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic [1:0]  be_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic        busy_o,
	input wire logic        arith_done_irq_o
);
	logic [5:0] cnt_ff; // Busy cycles of the running job
	logic       mul_ff; // Mode latched at launch
	wire logic  ctl_wr = wr_i && addr_i == MDU_IDX_ARITH_CTRL && be_i[0];
	wire logic  st_wr  = ctl_wr && wdata_i[7];
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// Length counter; aborts simply restart it at zero
	always_ff @(posedge clk_i or posedge reset_i)
		if (reset_i)
			cnt_ff <= 6'h00;
		else
			cnt_ff <= busy_o ? cnt_ff + 6'h01 : 6'h00;
	// Mode only counts when a launch is accepted
	always_ff @(posedge clk_i or posedge reset_i)
		if (reset_i)
			mul_ff <= 1'b0;
		else if (st_wr && !busy_o)
			mul_ff <= wdata_i[MDU_CTRL_SEL_POS];
	sequence s_start;
		st_wr && !busy_o;
	endsequence
	sequence s_end;
		!busy_o && arith_done_irq_o;
	endsequence
	a_start_busy: assert property
		(s_start |=> busy_o && !arith_done_irq_o)
		else $error("busy missing after launch");
	a_busy_hold: assert property (s_start |=> busy_o [*8])
		else $error("busy dropped early");
	a_mul_len: assert property
		(arith_done_irq_o && mul_ff |-> cnt_ff == MDU_MUL_CYCLES)
		else $error("multiply length wrong");
	a_div_len: assert property
		(arith_done_irq_o && !mul_ff |-> cnt_ff == MDU_DIV_CYCLES)
		else $error("divide length wrong");
	a_done_end: assert property (arith_done_irq_o |-> $fell(busy_o))
		else $error("done without busy end");
	a_done_pulse: assert property (s_end |=> !arith_done_irq_o)
		else $error("done longer than one cycle");
	a_busy_quiet: assert property (busy_o |-> !arith_done_irq_o)
		else $error("done while busy");
	a_busy_cause: assert property ($rose(busy_o) |-> $past(st_wr))
		else $error("busy rose without launch");
	a_ctrl_read: assert property (rd_i && addr_i == MDU_IDX_ARITH_CTRL
		|=> rdata_o[7] == $past(busy_o))
		else $error("start bit read wrong");
endmodule : mdu_top_asserts
bind mdu_top mdu_top_asserts u_mdu_top_asserts (.clk_i(clk_i),
	.reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .be_i(be_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .busy_o(busy_o),
	.arith_done_irq_o(arith_done_irq_o));
`default_nettype wire

// ---- sim/test_multiply_divide_unit.sv ----
`default_nettype none
`define MDU_CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_multiply_divide_unit
	import mdu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i, reset_i, wr_i, rd_i, busy_o, arith_done_irq_o, seen;
	logic [2:0]  addr_i;
	logic [15:0] wdata_i, rdata_o;
	logic [1:0]  be_i;
	int          num_errors, checked;
	// One job: inputs, then quotient or product and remainder
	typedef struct {logic m; logic [31:0] a; logic [15:0] b;
		logic [31:0] q; logic [15:0] r;} mdu_row_t;
	mdu_row_t    rows[7];
	mdu_top u_mdu_top (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .be_i(be_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .busy_o(busy_o),
		.arith_done_irq_o(arith_done_irq_o));
	// Unsigned, truncating results
	function automatic mdu_row_t mk(logic m, logic [31:0] a, logic [15:0] b);
		mk = '{m, a, b, m ? 32'(a[15:0]) * 32'(b) : a / 32'(b),
			m ? 16'h0000 : 16'(a % 32'(b))};
	endfunction : mk
	task automatic wr(logic [2:0] a, logic [15:0] d, logic [1:0] be);
		addr_i <= a;
		wdata_i <= d;
		be_i <= be;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask : wr
	// Data stands from the cycle after the strobe until the next read
	task automatic rd(logic [2:0] a, logic [15:0] e);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		`MDU_CHK(rdata_o, e)
		@(posedge clk_i);
	endtask : rd
	// Odd rows split halves into two byte writes
	task automatic put(logic [2:0] a, logic [15:0] v, logic s);
		if (s)
		begin
			wr(a, v, MDU_BE_LOW);
			wr(a, v, MDU_BE_HIGH);
		end
		else
			wr(a, v, 2'h3);
	endtask : put
	task automatic complete_run;
		if (num_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// Hang guard, far beyond the expected few hundred cycles
	initial
	begin
		#100000;
		num_errors++;
		complete_run;
	end
	initial
	begin
		{reset_i, wr_i, rd_i, addr_i, wdata_i, be_i} = {1'b1, 23'h0};
		// Multiplier rows keep the operand in A low, dividend whole
		// Every divisor below is nonzero
		rows = '{mk(1, 32'hbeef00da, 16'h0093), mk(0, 32'hdcba2586, 16'h0018),
			mk(1, 32'hffffffff, 16'hffff), mk(0, 32'hffffffff, 16'hffff),
			mk(1, 32'h12340000, 16'h5555), mk(0, 32'h00000005, 16'h0007),
			mk(0, 32'h80000000, 16'h0001)};
		repeat (20) @(posedge clk_i);
		reset_i <= 1'b0;
		for (int k = 0; k < 6; k++)
			rd(3'(k), 16'h0000);
		foreach (rows[i])
		begin
			put(MDU_IDX_OPA_UPPER, rows[i].a[31:16], i[0]);
			put(MDU_IDX_OPA_LOWER, rows[i].a[15:0], i[0]);
			put(MDU_IDX_OPB_DIVISOR, rows[i].b, i[0]);
			wr(MDU_IDX_ARITH_CTRL, {8'h00, 7'h40, rows[i].m}, 2'h3);
			seen = 1'b0;
			// No operand write or read until done
			for (int c = 0; c < 40 && !seen; c++)
			begin
				@(posedge clk_i);
				#1;
				seen = arith_done_irq_o;
			end
			@(posedge clk_i);
			`MDU_CHK(seen, 1'b1)
			rd(MDU_IDX_OPA_LOWER, rows[i].q[15:0]);
			rd(MDU_IDX_OPA_UPPER, rows[i].q[31:16]);
			rd(MDU_IDX_REM_RESULT, rows[i].r);
			rd(MDU_IDX_ARITH_CTRL, {15'h0000, rows[i].m});
		end
		// Clearing the start bit mid-divide stops it with no done
		wr(MDU_IDX_ARITH_CTRL, 16'h0080, 2'h3);
		repeat (10) @(posedge clk_i);
		wr(MDU_IDX_ARITH_CTRL, 16'h0000, 2'h3);
		`MDU_CHK(busy_o, 1'b0)
		seen = 1'b0;
		repeat (40)
		begin
			@(posedge clk_i);
			#1;
			seen |= arith_done_irq_o;
		end
		@(posedge clk_i);
		`MDU_CHK(seen, 1'b0)
		// Second reset in mid-multiply clears every register
		wr(MDU_IDX_ARITH_CTRL, 16'h0081, 2'h3);
		repeat (5) @(posedge clk_i);
		reset_i <= 1'b1;
		@(posedge clk_i);
		reset_i <= 1'b0;
		for (int k = 0; k < 5; k++)
			rd(3'(k), 16'h0000);
		complete_run;
	end
endmodule : test_multiply_divide_unit
`default_nettype wire
